// *** lro_pkg.sv ***
// constants, register map and core state type for the load and return decoder
package lro_pkg;

  // ****************************************
  // bus geometry and responses
  // ****************************************
  localparam int          ADDR_W      = 8;       // axi address width
  localparam logic [1:0]  RESP_OKAY   = 2'h0;    // normal answer
  localparam logic [1:0]  RESP_SLVERR = 2'h2;    // unmapped address answer

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [ADDR_W-1:0] REG_OPCODE = 8'h00; // write issues one opcode
  localparam logic [ADDR_W-1:0] REG_ACC    = 8'h04; // accumulator
  localparam logic [ADDR_W-1:0] REG_PTR    = 8'h08; // index, upper bit, page
  localparam logic [ADDR_W-1:0] REG_PC     = 8'h0c; // program counter
  localparam logic [ADDR_W-1:0] REG_STACK  = 8'h10; // both stack levels
  localparam logic [ADDR_W-1:0] REG_FLAGS  = 8'h14; // carry, status, skip
  localparam logic [ADDR_W-1:0] REG_PORTS  = 8'h18; // synchronised port pins

  // ****************************************
  // field positions
  // ****************************************
  localparam int PTR_L_LSB      = 0;   // pointer index word
  localparam int PTR_H_BIT      = 4;   // upper pointer bit
  localparam int PTR_Z_LSB      = 8;   // page select
  localparam int STACK_LVL1_LSB = 16;  // stack level one
  localparam int FLAG_CARRY_BIT = 0;   // carry flag
  localparam int FLAG_STAT_BIT  = 1;   // status flag
  localparam int FLAG_SKIP_BIT  = 2;   // previous opcode was an index immediate load
  localparam int PORT2_LSB      = 4;   // second port in the ports word

  // ****************************************
  // opcodes
  // ****************************************
  localparam logic [7:0] OP_NOP         = 8'h00; // no operation
  localparam logic [7:0] OP_ACC_PORT1   = 8'h14; // acc from port group one
  localparam logic [7:0] OP_ACC_PORT2   = 8'h12; // acc from port group two
  localparam logic [7:0] OP_ACC_UPPER   = 8'h11; // acc bit 0 from upper bit
  localparam logic [7:0] OP_ACC_INDEX   = 8'h16; // acc from index word
  localparam logic [7:0] OP_RET         = 8'h1d; // subroutine return
  localparam logic [7:0] OP_COMPL       = 8'h1c; // one's complement of acc
  localparam logic [7:0] IDX_IMM_MASK   = 8'hf0; // index immediate pattern mask
  localparam logic [7:0] IDX_IMM_MATCH  = 8'h40; // index immediate pattern
  localparam logic [7:0] PAGE_IMM_MASK  = 8'hf8; // page immediate pattern mask
  localparam logic [7:0] PAGE_IMM_MATCH = 8'h30; // page immediate pattern
  localparam logic [9:0] PC_STEP        = 10'h001; // one program word

  // ****************************************
  // core state carrier
  // ****************************************
  typedef struct packed {
    logic [9:0] pc;               // program counter
    logic [9:0] stack_level_zero; // return address on top
    logic [9:0] stack_level_one;  // older return address
    logic [3:0] acc;              // accumulator
    logic [3:0] l;                // pointer_index_word
    logic [2:0] z;                // page_select_nibble
    logic       h;                // upper_pointer_bit
    logic       carry_flag;       // carry, kept by every opcode here
    logic       status_flag;      // status, kept by every opcode here
    logic       index_load_prev;  // last opcode was an index immediate load
  } lro_core_s;

  localparam lro_core_s CORE_RST = '{default: '0}; // all state clear

endpackage : lro_pkg

// *** lro_sync2.sv ***
// two flip-flop synchroniser for asynchronous input pins
`timescale 1ns/1ps
`default_nettype none
module lro_sync2 #(
  parameter int WIDTH = 8                  // bits synchronised
) (
  input  wire logic             aclk,      // system clock
  input  wire logic             aresetn,   // synchronous reset, low
  input  wire logic [WIDTH-1:0] din,       // asynchronous pins
  output var  logic [WIDTH-1:0] dout       // synchronised copy
);
  logic [WIDTH-1:0] meta;                  // first stage, read by dout only

  // ****************************************
  // two stages, first one read by nothing else
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : lro_sync2
`default_nettype wire

// *** lro_decoder.sv ***
// load, complement and return execution unit behind an axi4-lite slave
// Function
// - opcode 14: accumulator takes port group one
// - opcode 12: accumulator takes port group two
// - opcode 11: upper pointer bit into accumulator bit0
// - opcode 16: accumulator takes pointer index word
// - 0100xxxx loads immediate into pointer index
// - back-to-back index immediate load is skipped
// - 00110xxx loads immediate into page select
// - complement inverts all four accumulator bits
// - return: pc from level zero, pop level one
`timescale 1ns/1ps
`default_nettype none
module lro_decoder (
  input  wire logic                      aclk,     // system clock, 100 mhz
  input  wire logic                      aresetn,  // synchronous reset, low
  input  wire logic [3:0]                port_one, // input_port_group_one pins
  input  wire logic [3:0]                port_two, // input_port_group_two pins
  input  wire logic [lro_pkg::ADDR_W-1:0] awaddr,  // write address
  input  wire logic                      awvalid,  // write address valid
  output var  logic                      awready,  // write address ready
  input  wire logic [31:0]               wdata,    // write data
  input  wire logic [3:0]                wstrb,    // write byte enables
  input  wire logic                      wvalid,   // write data valid
  output var  logic                      wready,   // write data ready
  output var  logic [1:0]                bresp,    // write response
  output var  logic                      bvalid,   // write response valid
  input  wire logic                      bready,   // write response ready
  input  wire logic [lro_pkg::ADDR_W-1:0] araddr,  // read address
  input  wire logic                      arvalid,  // read address valid
  output var  logic                      arready,  // read address ready
  output var  logic [31:0]               rdata,    // read data
  output var  logic [1:0]                rresp,    // read response
  output var  logic                      rvalid,   // read data valid
  input  wire logic                      rready    // read data ready
);
  // ****************************************
  // declarations
  // ****************************************
  lro_pkg::lro_core_s         core;       // architectural state
  lro_pkg::lro_core_s         next_core;  // state after the issued opcode
  logic [7:0]                 port_sync;  // {two, one} after synchroniser
  logic [lro_pkg::ADDR_W-1:0] aw_addr;    // held write address
  logic                       aw_held;    // write address captured
  logic [31:0]                w_data;     // held write data
  logic [3:0]                 w_strb;     // held byte enables
  logic                       w_held;     // write data captured
  logic                       do_write;   // both halves present
  logic                       exec;       // opcode issued this cycle
  logic [7:0]                 last_op;    // last issued opcode
  logic [7:0]                 op;         // opcode being issued

  // byte-lane merge of a write into an old register value
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  // true for a mapped register address
  function automatic logic mapped(input logic [lro_pkg::ADDR_W-1:0] a);
    return (a == lro_pkg::REG_OPCODE) || (a == lro_pkg::REG_ACC) ||
           (a == lro_pkg::REG_PTR) || (a == lro_pkg::REG_PC) ||
           (a == lro_pkg::REG_STACK) || (a == lro_pkg::REG_FLAGS) ||
           (a == lro_pkg::REG_PORTS);
  endfunction : mapped

  // pointer register word
  function automatic logic [31:0] ptr_word(input lro_pkg::lro_core_s c);
    logic [31:0] w;
    w = '0;
    w[lro_pkg::PTR_L_LSB +: 4] = c.l;
    w[lro_pkg::PTR_H_BIT]      = c.h;
    w[lro_pkg::PTR_Z_LSB +: 3] = c.z;
    return w;
  endfunction : ptr_word

  // stack register word
  function automatic logic [31:0] stack_word(input lro_pkg::lro_core_s c);
    logic [31:0] w;
    w = '0;
    w[9:0] = c.stack_level_zero;
    w[lro_pkg::STACK_LVL1_LSB +: 10] = c.stack_level_one;
    return w;
  endfunction : stack_word

  // flags register word
  function automatic logic [31:0] flag_word(input lro_pkg::lro_core_s c);
    logic [31:0] w;
    w = '0;
    w[lro_pkg::FLAG_CARRY_BIT] = c.carry_flag;
    w[lro_pkg::FLAG_STAT_BIT]  = c.status_flag;
    w[lro_pkg::FLAG_SKIP_BIT]  = c.index_load_prev;
    return w;
  endfunction : flag_word

  // ****************************************
  // pin synchroniser
  // ****************************************
  lro_sync2 #(.WIDTH(8)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({port_two, port_one}),
    .dout    (port_sync)
  );

  // ****************************************
  // write channels
  // ****************************************
  assign do_write = aw_held && w_held && !bvalid;
  assign op       = w_data[7:0];
  assign exec     = do_write && (aw_addr == lro_pkg::REG_OPCODE) && w_strb[0];

  // address and data taken in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
      bvalid  <= 1'b0;
      bresp   <= lro_pkg::RESP_OKAY;
    end else begin
      // each ready opens when its own channel holds nothing
      awready <= !aw_held && !(awvalid && awready);
      wready  <= !w_held && !(wvalid && wready);
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp  <= mapped(aw_addr) ? lro_pkg::RESP_OKAY : lro_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        // response taken, free both holders
        bvalid  <= 1'b0;
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
    end
  end

  // ****************************************
  // opcode execution
  // ****************************************
  // every opcode takes one cycle; all but return advance pc by one word
  always_comb begin
    next_core          = core;
    next_core.index_load_prev = 1'b0;
    next_core.pc = core.pc + lro_pkg::PC_STEP;
    if (op == lro_pkg::OP_ACC_PORT1) begin
      next_core.acc = port_sync[3:0];
    end else if (op == lro_pkg::OP_ACC_PORT2) begin
      next_core.acc = port_sync[lro_pkg::PORT2_LSB +: 4];
    end else if (op == lro_pkg::OP_ACC_UPPER) begin
      next_core.acc = {3'h0, core.h};
    end else if (op == lro_pkg::OP_ACC_INDEX) begin
      next_core.acc = core.l;
    end else if ((op & lro_pkg::IDX_IMM_MASK) == lro_pkg::IDX_IMM_MATCH) begin
      next_core.index_load_prev = 1'b1;
      if (!core.index_load_prev) begin
        next_core.l = op[3:0];
      end
    end else if ((op & lro_pkg::PAGE_IMM_MASK) == lro_pkg::PAGE_IMM_MATCH) begin
      next_core.z = op[2:0];
    end else if (op == lro_pkg::OP_COMPL) begin
      next_core.acc = ~core.acc;
    end else if (op == lro_pkg::OP_RET) begin
      next_core.pc               = core.stack_level_zero;
      next_core.stack_level_zero = core.stack_level_one;
    end
  end

  // core state: issued opcodes or direct register writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core    <= lro_pkg::CORE_RST;
      last_op <= lro_pkg::OP_NOP;
    end else if (exec) begin
      core    <= next_core;
      last_op <= op;
    end else if (do_write) begin
      if (aw_addr == lro_pkg::REG_ACC) begin
        core.acc <= 4'(merge({28'h0, core.acc}, w_data, w_strb));
      end else if (aw_addr == lro_pkg::REG_PTR) begin
        core.l <= 4'(merge(ptr_word(core), w_data, w_strb) >> lro_pkg::PTR_L_LSB);
        core.h <= 1'(merge(ptr_word(core), w_data, w_strb) >> lro_pkg::PTR_H_BIT);
        core.z <= 3'(merge(ptr_word(core), w_data, w_strb) >> lro_pkg::PTR_Z_LSB);
      end else if (aw_addr == lro_pkg::REG_PC) begin
        core.pc <= 10'(merge({22'h0, core.pc}, w_data, w_strb));
      end else if (aw_addr == lro_pkg::REG_STACK) begin
        core.stack_level_zero <= 10'(merge(stack_word(core), w_data, w_strb));
        core.stack_level_one  <= 10'(merge(stack_word(core), w_data, w_strb)
                                     >> lro_pkg::STACK_LVL1_LSB);
      end else if (aw_addr == lro_pkg::REG_FLAGS) begin
        core.carry_flag <= 1'(merge(flag_word(core), w_data, w_strb) >> lro_pkg::FLAG_CARRY_BIT);
        core.status_flag <= 1'(merge(flag_word(core), w_data, w_strb) >> lro_pkg::FLAG_STAT_BIT);
      end
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  // one read at a time, answer one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= lro_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= lro_pkg::RESP_OKAY;
      if (araddr == lro_pkg::REG_OPCODE) begin
        rdata <= {24'h0, last_op};
      end else if (araddr == lro_pkg::REG_ACC) begin
        rdata <= {28'h0, core.acc};
      end else if (araddr == lro_pkg::REG_PTR) begin
        rdata <= ptr_word(core);
      end else if (araddr == lro_pkg::REG_PC) begin
        rdata <= {22'h0, core.pc};
      end else if (araddr == lro_pkg::REG_STACK) begin
        rdata <= stack_word(core);
      end else if (araddr == lro_pkg::REG_FLAGS) begin
        rdata <= flag_word(core);
      end else if (araddr == lro_pkg::REG_PORTS) begin
        rdata <= {24'h0, port_sync};
      end else begin
        // unmapped: zero data, slave error
        rdata <= '0;
        rresp <= lro_pkg::RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else begin
      arready <= !rvalid;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  port_one_load_a: assert property (exec && op == lro_pkg::OP_ACC_PORT1 |=>
    core.acc == $past(port_sync[3:0])) else $error("port one load wrong");
  port_two_load_a: assert property (exec && op == lro_pkg::OP_ACC_PORT2 |=>
    core.acc == $past(port_sync[7:4])) else $error("port two load wrong");
  upper_bit_load_a: assert property (exec && op == lro_pkg::OP_ACC_UPPER |=>
    core.acc == {3'h0, $past(core.h)}) else $error("upper bit load wrong");
  index_load_a: assert property (exec && op == lro_pkg::OP_ACC_INDEX |=>
    core.acc == $past(core.l)) else $error("index load wrong");
  index_imm_a: assert property (exec && op[7:4] == 4'h4 && !core.index_load_prev |=>
    core.l == $past(op[3:0])) else $error("index immediate wrong");
  index_skip_a: assert property (exec && op[7:4] == 4'h4 && core.index_load_prev |=>
    $stable(core.l)) else $error("repeat not skipped");
  page_imm_a: assert property (exec && op[7:3] == 5'h06 |=>
    core.z == $past(op[2:0])) else $error("page immediate wrong");
  compl_acc_a: assert property (exec && op == lro_pkg::OP_COMPL |=>
    (core.acc ^ $past(core.acc)) == 4'hf) else $error("complement wrong");
  stack_pop_a: assert property (exec && op == lro_pkg::OP_RET |=>
    core.pc == $past(core.stack_level_zero) &&
    core.stack_level_zero == $past(core.stack_level_one)) else $error("return wrong");
  nop_only_pc_a: assert property (exec && op == lro_pkg::OP_NOP |=>
    core.pc == $past(core.pc) + 10'h001 && $stable(core.acc) && $stable(core.l) &&
    $stable(core.z) && $stable(core.stack_level_zero)) else $error("nop changed state");
  flags_kept_a: assert property (exec |=> $stable(core.carry_flag) &&
    $stable(core.status_flag) && bvalid) else $error("flags changed or no response");
endmodule : lro_decoder
`default_nettype wire

// *** lro_decoder_tb.sv ***
// self-checking bench for the load, complement and return decoder
`timescale 1ns/1ps
`default_nettype none
module lro_decoder_tb;
  // ****************************************
  // bench signals
  // ****************************************
  logic                        aclk;        // system clock
  logic                        aresetn;     // reset, low
  logic [3:0]                  port_one;    // first port pins
  logic [3:0]                  port_two;    // second port pins
  logic [lro_pkg::ADDR_W-1:0]  awaddr;      // write address
  logic                        awvalid;     // write address valid
  logic                        awready;     // write address ready
  logic [31:0]                 wdata;       // write data
  logic [3:0]                  wstrb;       // write byte enables
  logic                        wvalid;      // write data valid
  logic                        wready;      // write data ready
  logic [1:0]                  bresp;       // write response
  logic                        bvalid;      // write response valid
  logic                        bready;      // write response ready
  logic [lro_pkg::ADDR_W-1:0]  araddr;      // read address
  logic                        arvalid;     // read address valid
  logic                        arready;     // read address ready
  logic [31:0]                 rdata;       // read data
  logic [1:0]                  rresp;       // read response
  logic                        rvalid;      // read data valid
  logic                        rready;      // read data ready
  int                          n_fail;      // mismatches seen
  int                          checks_done; // comparisons made

  // unit under test
  lro_decoder i_dut (
    .aclk, .aresetn, .port_one, .port_two,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready
  );

  // free running 100 mhz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ****************************************
  // helpers
  // ****************************************
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one axi write, address and data offered together, waits for the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw_ok;
    bit w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // each channel released at its own handshake edge
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // bready held until the response is sampled; only the watchdog ends a hang
    do begin
      @(posedge aclk);
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge aclk);
  endtask : wr

  // one axi read, returns the data word
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
    end while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge aclk);
  endtask : rd

  // read a register and compare with the expected word
  task automatic look(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d, lro_pkg::RESP_OKAY);
    chk(d, exp);
  endtask : look

  // plain register write with a normal answer
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, lro_pkg::RESP_OKAY);
  endtask : put

  // issue one opcode
  task automatic run_op(input logic [7:0] op);
    put(lro_pkg::REG_OPCODE, {24'h0, op});
  endtask : run_op

  // ****************************************
  // scenarios
  // ****************************************
  // state after reset, unmapped place refused
  task automatic s_reset();
    logic [31:0] d;
    look(lro_pkg::REG_ACC, 32'h0);
    look(lro_pkg::REG_PTR, 32'h0);
    look(lro_pkg::REG_PC, 32'h0);
    look(lro_pkg::REG_FLAGS, 32'h0);
    rd(8'h1c, d, lro_pkg::RESP_SLVERR);
    chk(d, 32'h0);
    wr(8'h1c, 32'h0000_0005, lro_pkg::RESP_SLVERR);
  endtask : s_reset

  task automatic s_ports();
    logic [3:0] pat [2] = '{4'ha, 4'h5};
    put(lro_pkg::REG_FLAGS, 32'h0000_0003);
    for (int i = 0; i < 2; i++) begin
      port_one <= pat[i];
      port_two <= ~pat[i];
      repeat (4) @(posedge aclk);
      put(lro_pkg::REG_PC, 32'h0000_03fe);
      run_op(8'h14);
      look(lro_pkg::REG_ACC, {28'h0, pat[i]});
      run_op(8'h12);
      look(lro_pkg::REG_ACC, {28'h0, ~pat[i]});
      look(lro_pkg::REG_OPCODE, 32'h0000_0012);
      look(lro_pkg::REG_PORTS, {24'h0, ~pat[i], pat[i]});
      look(lro_pkg::REG_PC, 32'h0);
      look(lro_pkg::REG_FLAGS, 32'h0000_0003);
    end
  endtask : s_ports

  // upper bit and index word loads
  task automatic s_ptr();
    put(lro_pkg::REG_ACC, 32'h0000_000f);
    put(lro_pkg::REG_PTR, 32'h0000_0019);
    run_op(8'h11);
    look(lro_pkg::REG_ACC, 32'h0000_0001);
    put(lro_pkg::REG_PTR, 32'h0000_0009);
    put(lro_pkg::REG_ACC, 32'h0000_000f);
    run_op(8'h11);
    look(lro_pkg::REG_ACC, 32'h0);
    run_op(8'h16);
    look(lro_pkg::REG_ACC, 32'h0000_0009);
  endtask : s_ptr

  task automatic s_index();
    for (int n = 0; n < 16; n++) begin
      run_op(8'h00);
      run_op(8'h40 | n[7:0]);
      look(lro_pkg::REG_PTR, n);
      look(lro_pkg::REG_FLAGS, 32'h0000_0007);
    end
    run_op(8'h00);
    put(lro_pkg::REG_PC, 32'h0);
    run_op(8'h43);
    run_op(8'h47);
    run_op(8'h49);
    look(lro_pkg::REG_PTR, 32'h0000_0003);
    look(lro_pkg::REG_PC, 32'h0000_0003);
  endtask : s_index

  // page immediate over its whole range
  task automatic s_page();
    for (int n = 0; n < 8; n++) begin
      run_op(8'h30 | n[7:0]);
      look(lro_pkg::REG_PTR, 32'h0000_0003 | (n << 8));
    end
    // neighbouring pattern outside the page set
    run_op(8'h38);
    look(lro_pkg::REG_PTR, 32'h0000_0703);
  endtask : s_page

  task automatic s_compl();
    put(lro_pkg::REG_ACC, 32'h0000_0007);
    run_op(8'h1c);
    look(lro_pkg::REG_ACC, 32'h0000_0008);
    run_op(8'h1c);
    look(lro_pkg::REG_ACC, 32'h0000_0007);
  endtask : s_compl

  task automatic s_ret();
    put(lro_pkg::REG_STACK, 32'h02ab_0123);
    put(lro_pkg::REG_PC, 32'h0000_0055);
    run_op(8'h1d);
    look(lro_pkg::REG_PC, 32'h0000_0123);
    look(lro_pkg::REG_STACK, 32'h02ab_02ab);
    look(lro_pkg::REG_FLAGS, 32'h0000_0003);
  endtask : s_ret

  task automatic s_nop();
    put(lro_pkg::REG_PC, 32'h0000_0010);
    put(lro_pkg::REG_ACC, 32'h0000_0006);
    run_op(8'h00);
    look(lro_pkg::REG_PC, 32'h0000_0011);
    look(lro_pkg::REG_ACC, 32'h0000_0006);
    look(lro_pkg::REG_PTR, 32'h0000_0703);
    look(lro_pkg::REG_STACK, 32'h02ab_02ab);
    look(lro_pkg::REG_FLAGS, 32'h0000_0003);
  endtask : s_nop

  // ****************************************
  // verdict and run control
  // ****************************************
  // single place where the run ends
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // watchdog against a hung handshake: the scenarios need well under 2000
  // cycles, so 20000 cycles means a handshake never answered
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end

  // main sequence
  initial begin
    aresetn = 1'b0;
    port_one = 4'h0;
    port_two = 4'h0;
    awaddr = '0;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
    n_fail = 0;
    checks_done = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    s_reset();
    s_ports();
    s_ptr();
    s_index();
    s_page();
    s_compl();
    s_ret();
    s_nop();
    end_of_test();
  end
endmodule : lro_decoder_tb
`default_nettype wire
